// ---- src/idp_pkg.sv ----
/*
  Constants for the identify parameter word block: register offsets,
  field positions, reset values, word indices and fixed word values.
  Assumes a 32-bit AHB-Lite register bus and a 16-bit word stream.
*/
package idp_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int IDP_AW = 8;
  localparam logic [7:0] IDP_OFS_CFG = 8'h00;
  localparam logic [7:0] IDP_OFS_GEOM = 8'h04;
  localparam logic [7:0] IDP_OFS_SPT = 8'h08;
  localparam logic [7:0] IDP_OFS_LBA = 8'h0c;
  localparam logic [7:0] IDP_OFS_DMA = 8'h10;
  localparam logic [7:0] IDP_OFS_DMAT = 8'h14;
  localparam logic [7:0] IDP_OFS_PIOT = 8'h18;
  localparam logic [7:0] IDP_OFS_ADV = 8'h1c;
  localparam logic [7:0] IDP_OFS_STAT = 8'h20;
  localparam logic [2:0] IDP_HSIZE_WORD = 3'h2;
  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  localparam int IDP_CFG_W = 8;
  localparam int IDP_CF_SEL = 0;
  localparam int IDP_CF_MEDIA = 2;
  localparam int IDP_CF_FIXED = 3;
  localparam int IDP_CF_RET = 4;
  localparam int IDP_CF_CARD = 5;
  localparam int IDP_CF_PIO = 6;
  localparam logic [7:0] IDP_CFG_RST = 8'h00;
  localparam logic [1:0] IDP_SEL_SIG = 2'h0;
  localparam logic [1:0] IDP_SEL_KEEP = 2'h1;
  localparam logic [1:0] IDP_SEL_ZERO = 2'h2;
  localparam logic [1:0] IDP_SEL_BITS = 2'h3;
  localparam logic [1:0] IDP_PIO_MAX = 2'h2;
  // ----------------------------------------------------------------
  // Word values and indices
  // ----------------------------------------------------------------
  // Signature value is arbitrary; the word 0 checks rely only on its
  // 8h flag nibble and its 4h retired nibble
  localparam logic [15:0] IDP_W0_SIG = 16'h8431;
  localparam logic [15:0] IDP_W0_KEEP = 16'h044a;
  localparam logic [15:0] IDP_W0_ZERO = 16'h0040;
  localparam logic [3:0] IDP_FLAG_SIG = 4'h8;
  localparam logic [3:0] IDP_FLAG_BITS = 4'h0;
  localparam logic [3:0] IDP_RET_KEEP = 4'h4;
  localparam logic [5:0] IDP_LOW_KEEP = 6'h0a;
  localparam logic [15:0] IDP_W83_VAL = 16'h0004;
  localparam logic [7:0] IDP_I_PIO = 8'h33;
  localparam logic [7:0] IDP_I_VALID = 8'h35;
  localparam logic [7:0] IDP_I_CYL = 8'h36;
  localparam logic [7:0] IDP_I_HEAD = 8'h37;
  localparam logic [7:0] IDP_I_SPT = 8'h38;
  localparam logic [7:0] IDP_I_CAPL = 8'h39;
  localparam logic [7:0] IDP_I_CAPH = 8'h3a;
  localparam logic [7:0] IDP_I_MULT = 8'h3b;
  localparam logic [7:0] IDP_I_LBAL = 8'h3c;
  localparam logic [7:0] IDP_I_LBAH = 8'h3d;
  localparam logic [7:0] IDP_I_DMA = 8'h3f;
  localparam logic [7:0] IDP_I_DMIN = 8'h41;
  localparam logic [7:0] IDP_I_DREC = 8'h42;
  localparam logic [7:0] IDP_I_PMIN = 8'h43;
  localparam logic [7:0] IDP_I_PIOR = 8'h44;
  localparam logic [7:0] IDP_I_VER0 = 8'h50;
  localparam logic [7:0] IDP_I_VER1 = 8'h51;
  localparam logic [7:0] IDP_I_FEAT = 8'h53;
  localparam logic [7:0] IDP_I_ADVI = 8'ha3;
  localparam logic [7:0] IDP_I_ADVC = 8'ha4;
  localparam logic [7:0] IDP_I_LAST = 8'hff;
  // ----------------------------------------------------------------
  // Stream state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IDP_ST_IDLE = 2'b01,
    IDP_ST_SEND = 2'b10
  } idp_state_t;
endpackage : idp_pkg

// ---- src/idp_word_gen.sv ----
/*
  Combinational generator of one identify parameter word by index.
  Assumes all settings are stable while a block is being streamed.
*/
`timescale 1ns/1ns
`default_nettype none
module idp_word_gen
  import idp_pkg::*;
(
  input wire logic [7:0] word_idx,
  input wire logic [IDP_CFG_W-1:0] cfg,
  input wire logic [15:0] cyl,
  input wire logic [7:0] heads,
  input wire logic [7:0] spt,
  input wire logic [7:0] mult,
  input wire logic [31:0] lba,
  input wire logic [15:0] dma_sel,
  input wire logic [31:0] dma_time,
  input wire logic [31:0] pio_time,
  input wire logic [31:0] adv_mode,
  output logic [15:0] word
);
  logic card;
  logic ret;
  logic [31:0] cap;
  logic [15:0] w0;

  assign card = cfg[IDP_CF_CARD];
  assign ret = cfg[IDP_CF_RET];
  assign cap = 32'(cyl) * 32'(heads) * 32'(spt);

  // ----------------------------------------------------------------
  // Word 0
  // ----------------------------------------------------------------
  always_comb begin
    if (card) begin
      w0 = IDP_W0_SIG; // [R9] [R1]
    end else begin
      case (cfg[IDP_CF_SEL +: 2])
        IDP_SEL_KEEP: w0 = IDP_W0_KEEP; // [R4]
        IDP_SEL_ZERO: w0 = IDP_W0_ZERO; // [R5]
        IDP_SEL_BITS: w0 = {IDP_FLAG_BITS, // [R1] [R2]
                            ret ? IDP_RET_KEEP : 4'h0, // [R6]
                            cfg[IDP_CF_MEDIA], // [R7]
                            cfg[IDP_CF_FIXED], // [R8]
                            ret ? IDP_LOW_KEEP : 6'h00};
        default: w0 = IDP_W0_SIG; // [R1] [R2]
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Word table
  // ----------------------------------------------------------------
  always_comb begin
    case (word_idx)
      8'h00: word = w0;
      IDP_I_PIO: word = {6'h00, cfg[IDP_CF_PIO +: 2], 8'h00}; // [R13]
      IDP_I_VALID: word = {14'h0000, ~card, 1'b1};
      IDP_I_CYL: word = cyl; // [R16]
      IDP_I_HEAD: word = {8'h00, heads}; // [R16]
      IDP_I_SPT: word = {8'h00, spt}; // [R16]
      IDP_I_CAPL: word = cap[15:0]; // [R12]
      IDP_I_CAPH: word = cap[31:16]; // [R12]
      IDP_I_MULT: word = {7'h00, 1'b1, mult}; // [R17]
      IDP_I_LBAL: word = lba[15:0]; // [R16]
      IDP_I_LBAH: word = lba[31:16]; // [R16]
      IDP_I_DMA: word = card ? 16'h0000 : dma_sel; // [R10]
      IDP_I_DMIN: word = card ? 16'h0000 : dma_time[15:0]; // [R10]
      IDP_I_DREC: word = card ? 16'h0000 : dma_time[31:16]; // [R10]
      IDP_I_PMIN: word = pio_time[15:0]; // [R14]
      IDP_I_PIOR: word = pio_time[31:16]; // [R14]
      IDP_I_FEAT: word = IDP_W83_VAL; // [R3]
      IDP_I_ADVI: word = adv_mode[15:0]; // [R15]
      IDP_I_ADVC: word = adv_mode[31:16]; // [R15]
      // Version words 80 and 81 and all other words read zero
      default: word = 16'h0000; // [R11] [R20]
    endcase
  end
endmodule : idp_word_gen
`default_nettype wire

// ---- src/idp_identify.sv ----
/*
  Identify parameter block: settings registers on AHB-Lite and a
  256-word stream toward the data port logic of the card.
  Assumes start and ready come from logic on the same clock.
*/
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// (R1) Flag 8h gives signature word 0; flag 0h builds bits 11:0.
// (R2) Word 0 flag nibble is only ever 8h or 0h.
// (R3) With flag 0h, word 83 bit 2 reports card command set.
// (R4) Alternate word 0 value 044Ah may be selected.
// (R5) Alternate word 0 value 0040h may be selected.
// (R6) Retired bits 11-8 are 0h or 4h.
// (R7) Word 0 bit 7 shows removable media.
// (R8) Word 0 bit 6 shows a fixed, non-removable device.
// (R9) Removable-card modes report only the signature word 0.
// (R10) Removable-card modes return zero in words 63, 65 and 66.
// (R11) Words 80 and 81 read zero.
// (R12) Capacity: low half in word 57, high half in word 58.
// (R13) Word 51 holds PIO mode in upper byte, lower byte zero.
// (R14) Words 67 and 68 hold the minimum PIO cycle times.
// (R15) Words 163 and 164 hold advanced timing modes.
// (R16) LBA total in words 60-61; geometry in words 54-56.
// (R17) Word 59: bit 8 set, bits 15-9 zero, count in 7-0.
// (R18) PIO mode codes 0 to 2 only; higher codes are reserved.
// (R19) Words go out like a sector read; host takes all 256.
// (R20) Unset, reserved and obsolete words read zero.
// (R21) Words go out in ascending order, 0 to 255.
module idp_identify
  import idp_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ident_start,
  input wire logic word_ready,
  output logic word_valid,
  output logic [15:0] word_data,
  output logic ident_busy,
  output logic ident_done
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [IDP_CFG_W-1:0] cfg_ff, nxt_cfg;
  logic [31:0] geom_ff, nxt_geom;
  logic [15:0] spt_ff, nxt_spt;
  logic [31:0] lba_ff, nxt_lba;
  logic [15:0] dma_ff, nxt_dma;
  logic [31:0] dmat_ff, nxt_dmat;
  logic [31:0] piot_ff, nxt_piot;
  logic [31:0] adv_ff, nxt_adv;
  logic wpend_ff, nxt_wpend;
  logic [IDP_AW-1:0] waddr_ff, nxt_waddr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic ready_ff;
  logic addr_phase;
  idp_state_t state_ff, nxt_state;
  logic [7:0] idx_ff, nxt_idx;
  logic valid_ff, nxt_valid;
  logic [15:0] data_ff, nxt_data;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic [7:0] gen_idx;
  logic [15:0] gen_word;

  // ----------------------------------------------------------------
  // Word generator
  // ----------------------------------------------------------------
  // Idle looks ahead at word 0, sending looks at the next word
  assign gen_idx = (state_ff == IDP_ST_IDLE) ? 8'h00 : idx_ff + 8'h01;

  idp_word_gen u_gen (
    .word_idx(gen_idx),
    .cfg(cfg_ff),
    .cyl(geom_ff[15:0]),
    .heads(geom_ff[23:16]),
    .spt(spt_ff[7:0]),
    .mult(spt_ff[15:8]),
    .lba(lba_ff),
    .dma_sel(dma_ff),
    .dma_time(dmat_ff),
    .pio_time(piot_ff),
    .adv_mode(adv_ff),
    .word(gen_word)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign addr_phase = hsel && htrans[1] && hready;

  always_comb begin
    nxt_wpend = addr_phase && hwrite && (hsize == IDP_HSIZE_WORD);
    nxt_waddr = haddr[IDP_AW-1:0];
    nxt_rdata = 32'h0000_0000;
    if (addr_phase && !hwrite) begin
      case (haddr[IDP_AW-1:0])
        IDP_OFS_CFG: nxt_rdata = {24'h000000, cfg_ff};
        IDP_OFS_GEOM: nxt_rdata = geom_ff;
        IDP_OFS_SPT: nxt_rdata = {16'h0000, spt_ff};
        IDP_OFS_LBA: nxt_rdata = lba_ff;
        IDP_OFS_DMA: nxt_rdata = {16'h0000, dma_ff};
        IDP_OFS_DMAT: nxt_rdata = dmat_ff;
        IDP_OFS_PIOT: nxt_rdata = piot_ff;
        IDP_OFS_ADV: nxt_rdata = adv_ff;
        IDP_OFS_STAT: nxt_rdata = {16'h0000, idx_ff, 7'h00, busy_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    nxt_cfg = cfg_ff;
    nxt_geom = geom_ff;
    nxt_spt = spt_ff;
    nxt_lba = lba_ff;
    nxt_dma = dma_ff;
    nxt_dmat = dmat_ff;
    nxt_piot = piot_ff;
    nxt_adv = adv_ff;
    // Settings freeze while a block streams so all 256 words agree;
    // a start in the same cycle wins, as word 0 is latched from the old set
    if (wpend_ff && !busy_ff && !ident_start) begin
      case (waddr_ff)
        IDP_OFS_CFG: begin
          nxt_cfg = hwdata[IDP_CFG_W-1:0];
          if (hwdata[IDP_CF_PIO +: 2] > IDP_PIO_MAX) begin
            nxt_cfg[IDP_CF_PIO +: 2] = cfg_ff[IDP_CF_PIO +: 2]; // [R18]
          end
        end
        IDP_OFS_GEOM: nxt_geom = {8'h00, hwdata[23:0]};
        IDP_OFS_SPT: nxt_spt = hwdata[15:0];
        IDP_OFS_LBA: nxt_lba = hwdata;
        IDP_OFS_DMA: nxt_dma = hwdata[15:0];
        IDP_OFS_DMAT: nxt_dmat = hwdata;
        IDP_OFS_PIOT: nxt_piot = hwdata;
        IDP_OFS_ADV: nxt_adv = hwdata;
        default: nxt_cfg = cfg_ff;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cfg_ff <= IDP_CFG_RST;
      geom_ff <= 32'h0000_0000;
      spt_ff <= 16'h0000;
      lba_ff <= 32'h0000_0000;
      dma_ff <= 16'h0000;
      dmat_ff <= 32'h0000_0000;
      piot_ff <= 32'h0000_0000;
      adv_ff <= 32'h0000_0000;
      wpend_ff <= 1'b0;
      waddr_ff <= 8'h00;
      rdata_ff <= 32'h0000_0000;
      ready_ff <= 1'b1;
    end else begin
      cfg_ff <= nxt_cfg;
      geom_ff <= nxt_geom;
      spt_ff <= nxt_spt;
      lba_ff <= nxt_lba;
      dma_ff <= nxt_dma;
      dmat_ff <= nxt_dmat;
      piot_ff <= nxt_piot;
      adv_ff <= nxt_adv;
      wpend_ff <= nxt_wpend;
      waddr_ff <= nxt_waddr;
      rdata_ff <= nxt_rdata;
      ready_ff <= 1'b1;
    end
  end

  assign hreadyout = ready_ff;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;

  // ----------------------------------------------------------------
  // Word stream, one word per accepted handshake
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_valid = valid_ff;
    nxt_data = data_ff;
    nxt_done = 1'b0;
    case (state_ff)
      IDP_ST_IDLE: begin
        if (ident_start) begin
          nxt_state = IDP_ST_SEND; // [R19]
          nxt_idx = 8'h00; // [R21]
          nxt_valid = 1'b1;
          nxt_data = gen_word;
        end
      end
      IDP_ST_SEND: begin
        if (word_ready) begin
          if (idx_ff == IDP_I_LAST) begin
            nxt_state = IDP_ST_IDLE; // [R19]
            nxt_valid = 1'b0;
            nxt_data = 16'h0000;
            nxt_done = 1'b1;
          end else begin
            nxt_idx = idx_ff + 8'h01; // [R21]
            nxt_data = gen_word;
          end
        end
      end
      default: begin
        nxt_state = IDP_ST_IDLE;
        nxt_valid = 1'b0;
        nxt_data = 16'h0000;
      end
    endcase
    nxt_busy = (nxt_state == IDP_ST_SEND);
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_ff <= IDP_ST_IDLE;
      idx_ff <= 8'h00;
      valid_ff <= 1'b0;
      data_ff <= 16'h0000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      valid_ff <= nxt_valid;
      data_ff <= nxt_data;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
    end
  end

  assign word_valid = valid_ff;
  assign word_data = data_ff;
  assign ident_busy = busy_ff;
  assign ident_done = done_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic at_word;
  logic card_on;
  assign at_word = valid_ff;
  assign card_on = cfg_ff[IDP_CF_CARD];

  sequence s_start;
    state_ff == IDP_ST_IDLE && ident_start;
  endsequence
  sequence s_first;
    valid_ff && idx_ff == 8'h00 && busy_ff;
  endsequence

  chk_start_first: assert property (s_start |=> s_first) // [R19]
    else $error("start did not present word 0");
  chk_word0_flag: assert property (at_word && idx_ff == 8'h00 |->
    data_ff[15:12] == IDP_FLAG_SIG || data_ff[15:12] == IDP_FLAG_BITS)
    else $error("word 0 flag nibble illegal"); // [R2]
  chk_card_sig: assert property (at_word && idx_ff == 8'h00 && card_on
    |-> data_ff == IDP_W0_SIG) // [R9] [R1]
    else $error("card mode word 0 not signature");
  chk_retired_bits: assert property (at_word && idx_ff == 8'h00 |->
    data_ff[11:8] == 4'h0 || data_ff[11:8] == IDP_RET_KEEP) // [R6]
    else $error("retired nibble illegal");
  chk_word83_bit: assert property (at_word && idx_ff == IDP_I_FEAT
    |-> data_ff[2]) // [R3]
    else $error("word 83 bit 2 clear");
  chk_dma_zero: assert property (at_word && card_on &&
    (idx_ff == IDP_I_DMA || idx_ff == IDP_I_DMIN ||
     idx_ff == IDP_I_DREC) |-> data_ff == 16'h0000) // [R10]
    else $error("DMA word nonzero in card mode");
  chk_version_zero: assert property (at_word &&
    (idx_ff == IDP_I_VER0 || idx_ff == IDP_I_VER1) |->
    data_ff == 16'h0000) // [R11]
    else $error("version word nonzero");
  chk_pio_word: assert property (at_word && idx_ff == IDP_I_PIO |->
    data_ff[7:0] == 8'h00 && data_ff[15:8] <= 8'h02) // [R13] [R18]
    else $error("PIO mode word malformed");
  chk_mult_word: assert property (at_word && idx_ff == IDP_I_MULT |->
    data_ff[15:8] == 8'h01 && data_ff[7:0] == spt_ff[15:8]) // [R17]
    else $error("multiple sector word malformed");
  chk_cap_split: assert property (at_word && idx_ff == IDP_I_CAPL &&
    word_ready |=> data_ff ==
    32'(32'(geom_ff[15:0]) * 32'(geom_ff[23:16]) *
    32'(spt_ff[7:0])) >> 16) // [R12]
    else $error("capacity high half wrong");
  chk_word_order: assert property (valid_ff && word_ready &&
    idx_ff != IDP_I_LAST |=> valid_ff && idx_ff == $past(idx_ff) + 8'h01)
    else $error("words out of order"); // [R21]
  chk_last_done: assert property (valid_ff && word_ready &&
    idx_ff == IDP_I_LAST |=> ident_done && !valid_ff ##1 !ident_done)
    else $error("end of block not signalled"); // [R19]
endmodule : idp_identify
`default_nettype wire

// ---- test/ipw_host.sv ----
/*
  Host model that reads the identify word stream, like a sector read
  through the data port.
  Assumes it shares the clock and the reset of the block.
*/
`timescale 1ns/1ns
`default_nettype none
module ipw_host
  import idp_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic slow,
  input wire logic word_valid,
  input wire logic [15:0] word_data,
  output logic word_ready
);
  // ----------------------------------------------------------------
  // Capture of words in arrival order
  // ----------------------------------------------------------------
  logic [15:0] got [256];
  int count;

  // Slow mode stalls at random, so words must stand until taken
  always_ff @(posedge clock) begin
    if (!rstn) begin
      word_ready <= 1'b0;
      count <= 0;
    end else begin
      if (word_valid && word_ready) begin
        got[count[7:0]] <= word_data;
        count <= count + 1;
      end
      word_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
    end
  end
endmodule : ipw_host
`default_nettype wire

// ---- test/identify_param_words_test.sv ----
/*
  Self-checking bench for the identify word block: AHB-Lite register
  tasks, random settings and full 256-word reads by the host model.
  Assumes the slave answers with zero or more wait states.
*/
`timescale 1ns/1ns
`default_nettype none
module identify_param_words_test
  import idp_pkg::*;
;
  logic clock, rstn, hsel, hwrite, ident_start, slow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize, hsz;
  logic hreadyout, hresp, word_ready, word_valid, ident_busy, ident_done;
  logic [15:0] word_data;
  logic [31:0] regv [8];
  int mismatches, checks;

  idp_identify uut (.clock(clock), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ident_start(ident_start),
    .word_ready(word_ready), .word_valid(word_valid),
    .word_data(word_data), .ident_busy(ident_busy),
    .ident_done(ident_done));
  ipw_host host (.clock(clock), .rstn(rstn), .slow(slow),
    .word_valid(word_valid), .word_data(word_data),
    .word_ready(word_ready));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= hsz;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
    check(hresp === 1'b0, "bus response");
  endtask : bus

  function automatic logic [31:0] mask(input int i);
    case (i)
      0: mask = 32'h0000_00ff;
      1: mask = 32'h00ff_ffff;
      2, 4: mask = 32'h0000_ffff;
      default: mask = 32'hffff_ffff;
    endcase
  endfunction : mask

  function automatic logic [15:0] exp_word(input int i);
    logic [7:0] c;
    logic [31:0] cap;
    c = regv[0][7:0];
    cap = regv[1][15:0] * regv[1][23:16] * regv[2][7:0];
    case (i)
      0: begin
        if (c[5] || c[1:0] == 2'h0) exp_word = IDP_W0_SIG;
        else if (c[1:0] == 2'h1) exp_word = IDP_W0_KEEP;
        else if (c[1:0] == 2'h2) exp_word = IDP_W0_ZERO;
        else exp_word = {4'h0, c[4] ? 4'h4 : 4'h0, c[2], c[3],
          c[4] ? 6'h0a : 6'h00};
      end
      51: exp_word = {6'h0, c[7:6], 8'h00};
      53: exp_word = {14'h0, ~c[5], 1'b1};
      54: exp_word = regv[1][15:0];
      55: exp_word = {8'h0, regv[1][23:16]};
      56: exp_word = {8'h0, regv[2][7:0]};
      57: exp_word = cap[15:0];
      58: exp_word = cap[31:16];
      59: exp_word = {8'h01, regv[2][15:8]};
      60: exp_word = regv[3][15:0];
      61: exp_word = regv[3][31:16];
      63: exp_word = c[5] ? 16'h0 : regv[4][15:0];
      65: exp_word = c[5] ? 16'h0 : regv[5][15:0];
      66: exp_word = c[5] ? 16'h0 : regv[5][31:16];
      67: exp_word = regv[6][15:0];
      68: exp_word = regv[6][31:16];
      83: exp_word = IDP_W83_VAL;
      163: exp_word = regv[7][15:0];
      164: exp_word = regv[7][31:16];
      default: exp_word = 16'h0;
    endcase
  endfunction : exp_word

  // A write during the block must be dropped so the block stays whole
  task run_block(input logic busy_write);
    int n;
    int base;
    base = host.count;
    @(posedge clock);
    ident_start <= 1'b1;
    @(posedge clock);
    ident_start <= 1'b0;
    if (busy_write) begin
      bus(1'b1, IDP_OFS_CFG, 32'h0000_0041);
      bus(1'b0, IDP_OFS_STAT, 32'h0);
      check(rd[0] === 1'b1, "status busy");
    end
    n = 0;
    while (ident_done !== 1'b1 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    check(n < 3000 && ident_busy === 1'b0, "block end");
    @(posedge clock);
    check(ident_done === 1'b0, "done pulse");
    check(host.count - base == 256, "word count");
    for (int i = 0; i < 256; i++)
      check(host.got[i] === exp_word(i), $sformatf("word %0d", i));
    bus(1'b0, IDP_OFS_CFG, 32'h0);
    check(rd === regv[0], "cfg frozen");
  endtask : run_block

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    hsel = 1'b1;
    hwrite = 1'b0;
    ident_start = 1'b0;
    slow = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = IDP_HSIZE_WORD;
    hsz = IDP_HSIZE_WORD;
    mismatches = 0;
    checks = 0;
    void'($urandom(32'h8e7e));
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0);
      check(rd === 32'h0, "reset or unmapped value");
    end
    bus(1'b1, 8'h24, 32'hffff_ffff);
    bus(1'b0, 8'h24, 32'h0);
    check(rd === 32'h0, "unmapped write");
    $display("test reset done");
    hsz = 3'h0;
    bus(1'b1, IDP_OFS_CFG, 32'h3f);
    hsz = IDP_HSIZE_WORD;
    bus(1'b0, IDP_OFS_CFG, 32'h0);
    check(rd === 32'h0, "byte write");
    bus(1'b1, IDP_OFS_CFG, 32'hc5);
    bus(1'b0, IDP_OFS_CFG, 32'h0);
    check(rd === 32'h05, "pio code kept");
    $display("test write filters done");
    for (int t = 0; t < 8; t++) begin
      for (int i = 0; i < 8; i++) regv[i] = $urandom() & mask(i);
      regv[0][7:6] = 2'($urandom_range(0, 2));
      regv[0][5] = (t == 4 || t == 7);
      if (t < 4) regv[0][1:0] = 2'(t);
      slow <= t[0];
      for (int i = 0; i < 8; i++) bus(1'b1, 8'(i * 4), regv[i]);
      for (int i = 0; i < 8; i++) begin
        bus(1'b0, 8'(i * 4), 32'h0);
        check(rd === regv[i], "register readback");
      end
      run_block(t == 5);
      $display("test block %0d done", t);
    end
    // Reset in mid-block must drop the stream and clear the configuration register
    @(posedge clock);
    ident_start <= 1'b1;
    @(posedge clock);
    ident_start <= 1'b0;
    repeat (20) @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    check(word_valid === 1'b0 && ident_busy === 1'b0, "stream after reset");
    bus(1'b0, IDP_OFS_CFG, 32'h0);
    check(rd === 32'h0, "cfg after reset");
    $display("test mid reset done");
    complete_run();
  end

  initial begin
    #500000;
    mismatches++;
    complete_run();
  end
endmodule : identify_param_words_test
`default_nettype wire
